/* logic/som_pkg.sv */
// Package of constants and carrier types for the switch operating mode block.
package som_pkg;

  localparam int CLK_PERIOD_NS = 10;
  localparam int OSC_TICK_NS   = 1000;
  localparam int WDTO_MS       = 310;
  localparam int IN_TO_MS      = 250;
  localparam int NS_PER_MS     = 1000000;

  localparam int OSC_DIV_CYCLES = OSC_TICK_NS / CLK_PERIOD_NS;
  localparam int WDTO_TICKS     = WDTO_MS * (NS_PER_MS / OSC_TICK_NS);
  localparam int IN_TO_TICKS    = IN_TO_MS * (NS_PER_MS / OSC_TICK_NS);

  localparam int TMR_W = 24;
  localparam int DIV_W = 16;
  localparam int NUM_CH = 2;

  localparam int WATCHDOG_TOGGLE_BIT_POS = 15;
  localparam int WORD_W   = 16;

  localparam logic [1:0] DEFAULT_DELAY_CODE = 2'h0;
  localparam logic [1:0] DEFAULT_SLEW_CODE  = 2'h0;

  typedef enum logic [1:0] {
    MODE_SLEEP,
    MODE_NORMAL,
    MODE_FAILSAFE,
    MODE_FAULT
  } som_mode_e;

  typedef struct packed {
    logic       on_bit;
    logic       pwm_en;
    logic       dir_dis;
    logic       pwm_mod;
    logic [1:0] delay_code;
    logic [1:0] slew_code;
  } som_chcfg_s;

  typedef struct packed {
    logic [1:0] overcurrent_flag;
    logic [1:0] overtemperature_flag;
    logic [1:0] severe_short_flag;
    logic       undervoltage_flag;
    logic       overvoltage_flag;
  } som_faults_s;

  typedef struct packed {
    logic       hs_on;
    logic [1:0] delay_code;
    logic [1:0] slew_code;
  } som_drive_s;

  typedef struct packed {
    logic overcurrent;
    logic overtemperature;
    logic severe_short;
    logic undervoltage;
    logic overvoltage;
  } som_ch_fault_s;

  typedef struct packed {
    som_mode_e  mode;
    logic       normal;
    logic [1:0] ch_fault;
    logic [1:0] ch_on;
  } som_status_s;

  typedef struct packed {
    logic [TMR_W-1:0] cnt;
    logic             expired;
  } som_tmr_s;

  typedef struct packed {
    som_mode_e            mode;
    logic [DIV_W-1:0]     div_cnt;
    logic                 osc_tick;
    logic                 reset_release_pin_prev;
    logic [1:0]           in_prev;
    logic [1:0]           in_active;
    logic                 watchdog_toggle_bit_prev;
    logic                 wd_armed;
    logic                 wd_fail;
    logic                 exit_pend;
    logic                 vdd_seen;
    logic                 vdd_fail;
    logic                 fs_prev;
    logic                 failsafe_output_pin_drive;
    logic                 regs_reset;
    logic                 delatch;
    logic                 spi_enable;
    logic                 regs_default;
    logic                 access_block;
    logic                 normal;
    som_drive_s [1:0]     drive;
    som_status_s          status;
    som_ch_fault_s [1:0]  chfault;
  } som_ctl_s;

  localparam som_tmr_s SOM_TMR_RST = '0;
  localparam som_ctl_s SOM_CTL_RST = '0;

endpackage

/* logic/som_timeout.sv */
// Saturating timeout counter advanced by the oscillator tick enable.
`timescale 1ns/10ps
module som_timeout
  import som_pkg::*;
#(
  parameter logic [TMR_W-1:0] LIMIT = TMR_W'(WDTO_TICKS)
) (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic tick,
  input  wire logic run,
  input  wire logic restart,
  output logic      expired
);

  som_tmr_s q;
  som_tmr_s d;

  always_comb begin
    d = q;
    if (restart || !run) begin
      d = SOM_TMR_RST;
    end else if (tick && !q.expired) begin
      d.cnt = q.cnt + TMR_W'(1);
      if (q.cnt == LIMIT - TMR_W'(1)) begin
        d.expired = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q <= SOM_TMR_RST;
    end else begin
      q <= d;
    end
  end

  // The flag holds once reached until a restart or a low run input clears it.
  assign expired = q.expired;

endmodule

/* logic/som_mode_ctrl.sv */
// Operating mode controller and channel control selection of the switch.
//
// Overview of operation
// - Normal status flag is one only with wake-up set, fail-safe and fault clear.
// - Target on-state: direct input allowed, or on bit with PWM off or PWM modulation.
// - Direct input control uses default delay and slew codes, not programmed.
// - Rising reset-release or direct input wakes the device into normal mode.
// - Input-active flag drops after input inactivity longer than input timeout.
// - Both input flags low with reset-release low gives sleep mode.
// - Reset-release low or fail-safe: only direct inputs switch the channels.
// - Wake-up is reset-release OR either input-active flag.
// - Fail-safe set by watchdog timeout or logic supply loss when enabled.
// - Fault is OR of channel and supply faults, overvoltage qualified.
// - Priority: sleep, then fault, then fail-safe, otherwise normal.
// - Watchdog runs only with logic supply, not disabled, reset-release high.
// - Watchdog disable bit stops timeout from causing fail-safe entry.
// - Sleep turns channels and SPI off and holds registers at default.
// - After power-up the device rests in sleep mode.
// - Fail-safe entry drives fail-safe pin low, delatches, resets, blocks SPI.
// - Watchdog timer starts on reset-release rising edge with logic supply.
// - Missing watchdog bit change within timeout means lost link, fail-safe.
// - Status word shows per channel on/off and fault; fault register type.
// - Watchdog timeout is counted in internal oscillator ticks.
// - Watchdog bit is bit fifteen of every received word.
`timescale 1ns/10ps
module som_mode_ctrl
  import som_pkg::*;
#(
  parameter logic [DIV_W-1:0] OSC_DIV    = DIV_W'(OSC_DIV_CYCLES),
  parameter logic [TMR_W-1:0] WDTO_LIMIT = TMR_W'(WDTO_TICKS),
  parameter logic [TMR_W-1:0] INTO_LIMIT = TMR_W'(IN_TO_TICKS)
) (
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  input  wire logic              reset_release_pin,
  input  wire logic              vdd_present,
  input  wire logic [1:0]        in_pin,
  input  wire logic              rx_word_valid,
  input  wire logic [WORD_W-1:0] rx_word,
  input  wire logic              watchdog_disable_bit,
  input  wire logic              vdd_fail_en,
  input  wire logic              overvoltage_en,
  input  som_chcfg_s [1:0]       ch_cfg,
  input  som_faults_s            faults,
  output som_mode_e              mode,
  output logic                   normal_mode_flag,
  output som_drive_s [1:0]       drive,
  output logic                   failsafe_output_pin_o,
  output logic                   failsafe_output_pin_oe_n,
  output logic                   spi_enable,
  output logic                   spi_regs_default,
  output logic                   spi_regs_reset,
  output logic                   spi_access_block,
  output logic                   fault_delatch,
  output som_status_s            global_status_word,
  output som_ch_fault_s [1:0]    channel_fault_register
);

  function automatic logic som_rise(input logic prev, input logic cur);
    som_rise = cur && !prev;
  endfunction

  function automatic logic som_ch_fault(input som_faults_s f,
                                        input logic ov_en,
                                        input int ch);
    som_ch_fault = f.overcurrent_flag[ch] || f.overtemperature_flag[ch] ||
                   f.severe_short_flag[ch] || f.undervoltage_flag ||
                   (f.overvoltage_flag && ov_en);
  endfunction

  som_ctl_s q;
  som_ctl_s d;

  logic       wd_expired;
  logic [1:0] in_expired;
  logic       wd_run;
  logic       wd_restart;
  logic [1:0] in_restart;
  logic       reset_release_pin_rise;
  logic       watchdog_toggle_bit;
  logic       wd_toggle;

  // Watchdog timer conditions are needed by the timer instance as well.
  always_comb begin
    reset_release_pin_rise  = som_rise(q.reset_release_pin_prev, reset_release_pin);
    watchdog_toggle_bit       = rx_word[WATCHDOG_TOGGLE_BIT_POS];
    wd_toggle  = rx_word_valid && (watchdog_toggle_bit != q.watchdog_toggle_bit_prev);
    wd_run     = q.wd_armed && vdd_present && !watchdog_disable_bit &&
                 reset_release_pin &&
                 (q.mode == MODE_NORMAL || q.wd_fail);
    wd_restart = reset_release_pin_rise || wd_toggle ||
                 (rx_word_valid && q.wd_fail && !q.exit_pend);
    in_restart = in_pin | (in_pin ^ q.in_prev);
  end

  // The watchdog period is counted on oscillator ticks, not system clocks.
  som_timeout #(
    .LIMIT   (WDTO_LIMIT)
  ) u_wd_timer (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .tick    (q.osc_tick),
    .run     (wd_run),
    .restart (wd_restart),
    .expired (wd_expired)
  );

  som_timeout #(
    .LIMIT   (INTO_LIMIT)
  ) u_in0_timer (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .tick    (q.osc_tick),
    .run     (1'b1),
    .restart (in_restart[0]),
    .expired (in_expired[0])
  );

  som_timeout #(
    .LIMIT   (INTO_LIMIT)
  ) u_in1_timer (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .tick    (q.osc_tick),
    .run     (1'b1),
    .restart (in_restart[1]),
    .expired (in_expired[1])
  );

  always_comb begin
    logic       wake;
    logic       fault;
    logic       failsafe;
    logic       fs_entry;
    logic       direct_only;
    logic       spi_ctl;
    logic       dir_term;
    logic       spi_term;
    logic [1:0] ch_fault;
    som_mode_e  nmode;

    wake        = 1'b0;
    fault       = 1'b0;
    failsafe    = 1'b0;
    fs_entry    = 1'b0;
    direct_only = 1'b0;
    spi_ctl     = 1'b0;
    dir_term    = 1'b0;
    spi_term    = 1'b0;
    ch_fault    = 2'h0;
    nmode       = MODE_SLEEP;
    d           = q;

    // Oscillator tick divider.
    if (q.div_cnt >= OSC_DIV - DIV_W'(1)) begin
      d.div_cnt  = '0;
      d.osc_tick = 1'b1;
    end else begin
      d.div_cnt  = q.div_cnt + DIV_W'(1);
      d.osc_tick = 1'b0;
    end

    d.reset_release_pin_prev = reset_release_pin;
    d.in_prev   = in_pin;

    // Input activity flags; a fresh rising edge wins over a timeout.
    for (int i = 0; i < NUM_CH; i++) begin
      if (som_rise(q.in_prev[i], in_pin[i])) begin
        d.in_active[i] = 1'b1;
      end else if (in_expired[i]) begin
        d.in_active[i] = 1'b0;
      end
    end

    // Watchdog arming follows the reset-release pin.
    if (reset_release_pin_rise && vdd_present) begin
      d.wd_armed = 1'b1;
    end else if (!reset_release_pin) begin
      d.wd_armed = 1'b0;
    end

    if (rx_word_valid) begin
      d.watchdog_toggle_bit_prev = watchdog_toggle_bit;
    end

    // A timeout beats any exit attempt in the same cycle.
    if (wd_expired && wd_run && !watchdog_disable_bit) begin
      d.wd_fail   = 1'b1;
      d.exit_pend = 1'b0;
    end else if (!reset_release_pin || watchdog_disable_bit) begin
      d.wd_fail   = 1'b0;
      d.exit_pend = 1'b0;
    end else if (q.wd_fail && rx_word_valid) begin
      if (q.exit_pend) begin
        d.wd_fail   = 1'b0;
        d.exit_pend = 1'b0;
      end else if (watchdog_toggle_bit) begin
        d.exit_pend = 1'b1;
      end
    end

    // Supply loss only counts after the logic supply was once present.
    if (vdd_present) begin
      d.vdd_seen = 1'b1;
    end
    if (q.vdd_seen && !vdd_present && vdd_fail_en) begin
      d.vdd_fail = 1'b1;
    end else if (vdd_present) begin
      d.vdd_fail = 1'b0;
    end

    wake = reset_release_pin || q.in_active[0] || q.in_active[1];
    for (int i = 0; i < NUM_CH; i++) begin
      ch_fault[i] = som_ch_fault(faults, overvoltage_en, i);
    end
    fault    = |ch_fault;
    failsafe = q.wd_fail || q.vdd_fail;

    if (!wake) begin
      nmode = MODE_SLEEP;
    end else if (fault) begin
      nmode = MODE_FAULT;
    end else if (failsafe) begin
      nmode = MODE_FAILSAFE;
    end else begin
      nmode = MODE_NORMAL;
    end
    d.mode   = nmode;
    d.normal = wake && !failsafe && !fault;

    // Entry covers fault mode too, so a fail-safe over a fault delatches.
    d.fs_prev    = wake && failsafe;
    fs_entry     = wake && failsafe && !q.fs_prev;
    d.regs_reset = fs_entry;
    d.delatch    = fs_entry;
    d.failsafe_output_pin_drive = wake && failsafe;

    d.spi_enable   = wake;
    d.regs_default = !wake;
    d.access_block = wake && failsafe;

    direct_only = !reset_release_pin || failsafe;
    spi_ctl     = !direct_only;
    for (int i = 0; i < NUM_CH; i++) begin
      dir_term = in_pin[i] && (!ch_cfg[i].dir_dis || direct_only);
      spi_term = spi_ctl && ch_cfg[i].on_bit &&
                 (!ch_cfg[i].pwm_en || ch_cfg[i].pwm_mod);
      if (nmode == MODE_SLEEP || nmode == MODE_FAULT) begin
        d.drive[i].hs_on = 1'b0;
      end else begin
        d.drive[i].hs_on = dir_term || spi_term;
      end
      if (direct_only || (dir_term && !spi_term)) begin
        d.drive[i].delay_code = DEFAULT_DELAY_CODE;
        d.drive[i].slew_code  = DEFAULT_SLEW_CODE;
      end else begin
        d.drive[i].delay_code = ch_cfg[i].delay_code;
        d.drive[i].slew_code  = ch_cfg[i].slew_code;
      end
      d.chfault[i].overcurrent     = faults.overcurrent_flag[i];
      d.chfault[i].overtemperature = faults.overtemperature_flag[i];
      d.chfault[i].severe_short    = faults.severe_short_flag[i];
      d.chfault[i].undervoltage    = faults.undervoltage_flag;
      d.chfault[i].overvoltage     = faults.overvoltage_flag &&
                                     overvoltage_en;
      d.status.ch_on[i]    = q.drive[i].hs_on;
      d.status.ch_fault[i] = ch_fault[i];
    end
    d.status.mode   = q.mode;
    d.status.normal = q.normal;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q <= SOM_CTL_RST;
    end else begin
      q <= d;
    end
  end

  assign mode                     = q.mode;
  assign normal_mode_flag         = q.normal;
  assign drive                    = q.drive;
  assign failsafe_output_pin_o    = 1'b0;
  assign failsafe_output_pin_oe_n = !q.failsafe_output_pin_drive;
  assign spi_enable               = q.spi_enable;
  assign spi_regs_default         = q.regs_default;
  assign spi_regs_reset           = q.regs_reset;
  assign spi_access_block         = q.access_block;
  assign fault_delatch            = q.delatch;
  assign global_status_word       = q.status;
  assign channel_fault_register   = q.chfault;

endmodule

/* tb/som_mode_ctrl_sva.sv */
// Concurrent checks on the ports of the operating mode controller.
`timescale 1ns/10ps
module som_mode_ctrl_chk
  import som_pkg::*;
(
  input wire logic           clk_sys,
  input wire logic           rst_n,
  input wire logic           reset_release_pin,
  input wire logic           vdd_present,
  input wire logic [1:0]     in_pin,
  input wire logic           overvoltage_en,
  input som_chcfg_s [1:0]    ch_cfg,
  input som_faults_s         faults,
  input som_mode_e           mode,
  input wire logic           normal_mode_flag,
  input som_drive_s [1:0]    drive,
  input wire logic           failsafe_output_pin_o,
  input wire logic           failsafe_output_pin_oe_n,
  input wire logic           spi_enable,
  input wire logic           spi_regs_default,
  input wire logic           spi_regs_reset,
  input wire logic           spi_access_block,
  input wire logic           fault_delatch,
  input som_ch_fault_s [1:0] channel_fault_register
);
  logic [1:0] hson_w;
  logic [1:0] on_w;
  assign on_w[0] = ch_cfg[0].on_bit & (~ch_cfg[0].pwm_en | ch_cfg[0].pwm_mod);
  assign on_w[1] = ch_cfg[1].on_bit & (~ch_cfg[1].pwm_en | ch_cfg[1].pwm_mod);
  assign hson_w = (in_pin & ~{ch_cfg[1].dir_dis, ch_cfg[0].dir_dis}) | on_w;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_fs_entry;
    $past(mode) == MODE_NORMAL && mode == MODE_FAILSAFE;
  endsequence
  sequence s_pulse_end;
    !spi_regs_reset && !fault_delatch;
  endsequence

  property p_flag; normal_mode_flag == (mode == MODE_NORMAL); endproperty
  a_flag: assert property (p_flag) else $error("normal flag wrong");
  property p_hson;
    mode == MODE_NORMAL && $past(mode) == MODE_NORMAL && $past(reset_release_pin)
      |-> {drive[1].hs_on, drive[0].hs_on} == $past(hson_w);
  endproperty
  a_hson: assert property (p_hson) else $error("hs_on wrong");
  property p_direct;
    mode == MODE_FAILSAFE && $past(mode) == MODE_FAILSAFE
      && $past(ch_cfg[0].dir_dis | ch_cfg[1].dir_dis) == 1'b0
      |-> {drive[1].hs_on, drive[0].hs_on} == $past(in_pin)
      && drive[0].delay_code == DEFAULT_DELAY_CODE
      && drive[0].slew_code == DEFAULT_SLEW_CODE;
  endproperty
  a_direct: assert property (p_direct) else $error("direct drive wrong");
  property p_off;
    (mode == MODE_SLEEP || mode == MODE_FAULT) && $past(mode) == mode
      |-> !drive[0].hs_on && !drive[1].hs_on;
  endproperty
  a_off: assert property (p_off) else $error("channel on when off");
  property p_sleep_spi;
    mode == MODE_SLEEP [*3] |-> spi_regs_default && !spi_enable;
  endproperty
  a_sleep_spi: assert property (p_sleep_spi) else $error("sleep spi");
  property p_fs_pin;
    mode == MODE_FAILSAFE
      |-> !failsafe_output_pin_oe_n && !failsafe_output_pin_o && spi_access_block;
  endproperty
  a_fs_pin: assert property (p_fs_pin) else $error("fail-safe pin");
  property p_fs_entry;
    s_fs_entry |-> spi_regs_reset && fault_delatch ##1 s_pulse_end;
  endproperty
  a_fs_entry: assert property (p_fs_entry) else $error("entry pulse");
  property p_wake;
    mode == MODE_SLEEP && $rose(reset_release_pin) && vdd_present
      && faults == '0 |=> mode == MODE_NORMAL;
  endproperty
  a_wake: assert property (p_wake) else $error("wake failed");
  property p_fault;
    reset_release_pin && $past(reset_release_pin) && |faults[7:1]
      |=> mode == MODE_FAULT;
  endproperty
  a_fault: assert property (p_fault) else $error("fault mode missed");
  property p_mirror;
    channel_fault_register[1].overvoltage
      == $past(faults.overvoltage_flag & overvoltage_en)
      && channel_fault_register[0].overcurrent
      == $past(faults.overcurrent_flag[0]);
  endproperty
  a_mirror: assert property (p_mirror) else $error("fault mirror");
endmodule

bind som_mode_ctrl som_mode_ctrl_chk u_chk (
  .clk_sys, .rst_n, .reset_release_pin, .vdd_present, .in_pin,
  .overvoltage_en, .ch_cfg, .faults, .mode, .normal_mode_flag, .drive,
  .failsafe_output_pin_o, .failsafe_output_pin_oe_n, .spi_enable,
  .spi_regs_default, .spi_regs_reset, .spi_access_block, .fault_delatch,
  .channel_fault_register
);

/* tb/som_spi_host.sv */
// Host model that hands over received words with a toggling watchdog bit.
`timescale 1ns/10ps
module som_spi_host
  import som_pkg::*;
(
  input  wire logic          clk_sys,
  input  wire logic          run,
  output logic               rx_word_valid,
  output logic [WORD_W-1:0]  rx_word
);
  int   gap_cnt   = 0;
  logic wd_bit_q  = 1'b0;
  initial begin
    rx_word_valid = 1'b0;
    rx_word = 16'h0000;
  end
  // Between words the data is inverted, so a design that samples it
  // without the valid pulse cannot pass by luck.
  always @(negedge clk_sys) begin
    if (run && gap_cnt >= 9) begin
      gap_cnt <= 0;
      rx_word_valid <= 1'b1;
      rx_word <= {~wd_bit_q, 15'($urandom)};
      wd_bit_q <= ~wd_bit_q;
    end else begin
      rx_word_valid <= 1'b0;
      rx_word <= ~rx_word;
      gap_cnt <= gap_cnt + 1;
    end
  end
endmodule

/* tb/testbench.sv */
// Self-checking bench for the operating mode controller.
`timescale 1ns/10ps
module testbench;
  import som_pkg::*;
  localparam logic [DIV_W-1:0] DIV = 16'h0002;
  localparam logic [TMR_W-1:0] WDL = 24'h000014;
  localparam logic [TMR_W-1:0] INL = 24'h00000f;
  localparam int WD_CYC = int'(WDL) * int'(DIV);
  localparam int IN_CYC = int'(INL) * int'(DIV);
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic reset_release_pin = 1'b0;
  logic vdd_present = 1'b1;
  logic [1:0] in_pin = 2'h0;
  logic watchdog_disable_bit = 1'b0;
  logic vdd_fail_en = 1'b0;
  logic overvoltage_en = 1'b0;
  logic host_run = 1'b0;
  som_chcfg_s [1:0] ch_cfg = '0;
  som_faults_s faults = '0;
  logic rx_word_valid;
  logic [WORD_W-1:0] rx_word;
  som_mode_e mode;
  som_drive_s [1:0] drive;
  som_status_s global_status_word;
  som_ch_fault_s [1:0] channel_fault_register;
  logic normal_mode_flag, failsafe_output_pin_o, failsafe_output_pin_oe_n;
  logic spi_enable, spi_regs_default, spi_regs_reset;
  logic spi_access_block, fault_delatch;
  int error_cnt = 0;
  int comparisons = 0;
  int cyc = 0;

  som_mode_ctrl #(.OSC_DIV(DIV), .WDTO_LIMIT(WDL), .INTO_LIMIT(INL)) dut (
    .clk_sys, .rst_n, .reset_release_pin, .vdd_present, .in_pin,
    .rx_word_valid, .rx_word, .watchdog_disable_bit, .vdd_fail_en,
    .overvoltage_en, .ch_cfg, .faults, .mode, .normal_mode_flag, .drive,
    .failsafe_output_pin_o, .failsafe_output_pin_oe_n, .spi_enable,
    .spi_regs_default, .spi_regs_reset, .spi_access_block, .fault_delatch,
    .global_status_word, .channel_fault_register);
  som_spi_host u_host (.clk_sys, .run(host_run), .rx_word_valid, .rx_word);

  function automatic som_mode_e exp_mode(bit wake, bit fs, bit flt);
    if (!wake) return MODE_SLEEP;
    if (flt) return MODE_FAULT;
    return fs ? MODE_FAILSAFE : MODE_NORMAL;
  endfunction
  function automatic bit exp_on(som_chcfg_s c, bit i);
    return (i && !c.dir_dis) || (c.on_bit && (!c.pwm_en || c.pwm_mod));
  endfunction
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic step(int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic wait_mode(som_mode_e m, int lim, output int n);
    n = 0;
    while (mode !== m && n < lim) begin
      step(1);
      n++;
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial forever #5 clk_sys = ~clk_sys;
  // A hung wait must still end in the report.
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      summarize();
    end
  end

  initial begin
    int n;
    void'($urandom(32'h5676));
    step(12);
    rst_n = 1'b1;
    step(2);
    chk("mode", exp_mode(0, 0, 0), mode);
    chk("regs_default", 8'h01, spi_regs_default);
    $display("test reset done");
    host_run = 1'b1;
    reset_release_pin = 1'b1;
    step(2);
    chk("mode", exp_mode(1, 0, 0), mode);
    chk("nm_flag", 8'h01, normal_mode_flag);
    step(100);
    chk("mode", exp_mode(1, 0, 0), mode);
    chk("stat_mode", MODE_NORMAL, global_status_word.mode);
    chk("stat_normal", 8'h01, global_status_word.normal);
    $display("test wake done");
    repeat (20) begin
      ch_cfg = 16'($urandom);
      in_pin = 2'($urandom);
      step(1);
      chk("hs_on0", exp_on(ch_cfg[0], in_pin[0]), drive[0].hs_on);
      chk("hs_on1", exp_on(ch_cfg[1], in_pin[1]), drive[1].hs_on);
    end
    ch_cfg = '0;
    ch_cfg[0].delay_code = 2'h3;
    ch_cfg[0].slew_code = 2'h3;
    in_pin = 2'h1;
    step(1);
    chk("delay0", DEFAULT_DELAY_CODE, drive[0].delay_code);
    chk("slew0", DEFAULT_SLEW_CODE, drive[0].slew_code);
    $display("test channel control done");
    ch_cfg = '0;
    ch_cfg[0].on_bit = 1'b1;
    in_pin = 2'h0;
    for (int b = 0; b < 9; b++) begin
      overvoltage_en = (b == 8);
      faults = (b == 8) ? 8'h01 : 8'h01 << b;
      step(2);
      chk("fault_mode", exp_mode(1, 0, b != 0), mode);
      chk("hs_on0", 8'(b == 0), drive[0].hs_on);
      chk("stat_fault", (b == 0) ? 8'h00 : (b == 1 || b == 8) ? 8'h03 :
          ((b % 2) == 0) ? 8'h01 : 8'h02,
          global_status_word.ch_fault);
      faults = '0;
      step(2);
    end
    $display("test faults done");
    ch_cfg = '0;
    ch_cfg[1].on_bit = 1'b1;
    in_pin = 2'h1;
    host_run = 1'b0;
    wait_mode(MODE_FAILSAFE, 80, n);
    chk("wd_time", 8'h01, 8'(n >= WD_CYC - 14 && n <= WD_CYC + 8));
    step(1);
    chk("failsafe_output_pin_oe_n", 8'h00, failsafe_output_pin_oe_n);
    chk("hs_on0", 8'h01, drive[0].hs_on);
    chk("hs_on1", 8'h00, drive[1].hs_on);
    host_run = 1'b1;
    wait_mode(MODE_NORMAL, 60, n);
    chk("mode", exp_mode(1, 0, 0), mode);
    $display("test watchdog done");
    watchdog_disable_bit = 1'b1;
    host_run = 1'b0;
    step(2 * WD_CYC);
    chk("mode", exp_mode(1, 0, 0), mode);
    host_run = 1'b1;
    step(20);
    watchdog_disable_bit = 1'b0;
    vdd_fail_en = 1'b1;
    vdd_present = 1'b0;
    step(3);
    chk("mode", exp_mode(1, 1, 0), mode);
    vdd_present = 1'b1;
    step(3);
    chk("mode", exp_mode(1, 0, 0), mode);
    $display("test disable and supply done");
    host_run = 1'b0;
    ch_cfg = '0;
    ch_cfg[0].on_bit = 1'b1;
    in_pin = 2'h0;
    reset_release_pin = 1'b0;
    wait_mode(MODE_SLEEP, 60, n);
    chk("to_sleep", 8'h01, 8'(n >= IN_CYC - 4 && n <= IN_CYC + 6));
    chk("spi_enable", 8'h00, spi_enable);
    in_pin = 2'h2;
    step(3);
    chk("mode", exp_mode(1, 0, 0), mode);
    chk("hs_on0", 8'h00, drive[0].hs_on);
    chk("hs_on1", 8'h01, drive[1].hs_on);
    $display("test sleep done");
    summarize();
  end
endmodule
